// file: core/rnac_params.svh
// constants for the radio notifier and amplifier pin controller
`ifndef RNAC_PARAMS_SVH
`define RNAC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RNAC_OFS_CTRL     8'h00
`define RNAC_OFS_DIST     8'h04
`define RNAC_OFS_PREP     8'h08
`define RNAC_OFS_STATUS   8'h0c
`define RNAC_OFS_MASK     8'h10
`define RNAC_OFS_STATE    8'h14

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define RNAC_CTRL_PRE_EN   0
`define RNAC_CTRL_POST_EN  1
`define RNAC_CTRL_AMP_EN   2
`define RNAC_CTRL_TX_POL   3
`define RNAC_CTRL_RX_POL   4

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define RNAC_ST_PRE    0
`define RNAC_ST_POST   1
`define RNAC_ST_PREP   2

// ----------------------------------------------------------------
// reset values, lead distances in microseconds
// ----------------------------------------------------------------
`define RNAC_CTRL_RST      8'h00
`define RNAC_DIST_RST_US   16'd1740
`define RNAC_PREP_RST_US   16'd100
`define RNAC_MASK_RST      3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RNAC_CLK_MHZ       40
`define RNAC_AMP_LEAD_US   5
`define RNAC_AMP_LEAD_CYC  (`RNAC_AMP_LEAD_US * `RNAC_CLK_MHZ)

`endif

// file: core/rnac_pkg.sv
// types for the radio notifier and amplifier pin controller
package rnac_pkg;
   typedef enum logic [1:0] {
      RNAC_IDLE = 2'b00,
      RNAC_LEAD = 2'b01,
      RNAC_BUSY = 2'b10
   } rnac_state_e;
endpackage

// file: core/rnac_us_timer.sv
// microsecond down counter with a one-cycle expiry pulse
`timescale 1ns/1ps
module rnac_us_timer #(
   parameter int CLK_MHZ = 40,
   parameter int W       = 16
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] load_us,
   input  wire logic         stop,
   output logic              running,
   output logic              expired
);
   localparam int PW = $clog2(CLK_MHZ + 1);
   logic [PW-1:0] pre;
   logic [W-1:0]  count;

   if (CLK_MHZ < 1 || W < 2) begin
      $error("rnac_us_timer: bad parameters");
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pre     <= '0;
         count   <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (load) begin
            pre     <= PW'(CLK_MHZ - 1);
            count   <= load_us;
            running <= (load_us != '0);
            expired <= (load_us == '0);
         end else if (stop) begin
            running <= 1'b0;
         end else if (running) begin
            if (pre != '0) begin
               pre <= pre - 1'b1;
            end else begin
               pre <= PW'(CLK_MHZ - 1);
               if (count == W'(1)) begin
                  running <= 1'b0;
                  expired <= 1'b1;
               end
               count <= count - 1'b1;
            end
         end
      end
   end
endmodule

// file: core/rnac_top.sv
// radio activity notifier and amplifier pin controller
//
// Operation
// - pre notice before, post notice after
// - one interrupt line, pre before post
// - pre notice lead equals programmed distance
// - prep interrupt at prep lead before start
// - broadcast long lead: one pair per event
// - broadcast 800us: master gets extra pair
// - burst long lead: one pair whole burst
// - burst 1740us: slave gets extra pair
// - burst 800us may give stray pairs
// - amplifier pins idle until enabled
// - tx and rx pins, own polarity
// - pin active 5us before ready
// - disabled event releases the pins
// - short gap suppresses inner notices
`timescale 1ns/1ps
`include "rnac_params.svh"
module rnac_top
   import rnac_pkg::*;
#(
   parameter int DIST_W = 16
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   // scheduler announces an event: start_in_us until first rx/tx
   input  wire logic        evt_sched,
   input  wire logic [DIST_W-1:0] evt_start_us,
   input  wire logic        evt_is_tx,
   input  wire logic        evt_begin,
   input  wire logic        evt_end,
   input  wire logic        more_pending,
   input  wire logic [DIST_W-1:0] next_gap_us,
   // radio ramp is planned; ready follows after the amp lead
   input  wire logic        radio_ramp_start,
   input  wire logic        radio_disabled,
   output logic             notice_irq,
   output logic             prep_irq,
   output logic             radio_done_notice,
   output logic             tx_amp_pin,
   output logic             rx_amp_pin
);
   // refuse lead distance widths outside 12 to 16 bits
   if (DIST_W < 12 || DIST_W > 16) begin
      $error("rnac_top: DIST_W out of range");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]        ctrl;
   logic [DIST_W-1:0] dist_us;
   logic [DIST_W-1:0] prep_us;
   logic [2:0]        status;
   logic [2:0]        mask;
   rnac_state_e       state;
   logic              in_chain;
   logic              amp_tx_on;
   logic              amp_rx_on;
   logic              ev_pre;
   logic              ev_post;
   logic              ev_prep;

   wire pre_en  = ctrl[`RNAC_CTRL_PRE_EN];
   wire post_en = ctrl[`RNAC_CTRL_POST_EN];
   wire amp_en  = ctrl[`RNAC_CTRL_AMP_EN];
   wire tx_pol  = ctrl[`RNAC_CTRL_TX_POL];
   wire rx_pol  = ctrl[`RNAC_CTRL_RX_POL];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl    <= `RNAC_CTRL_RST;
         dist_us <= DIST_W'(`RNAC_DIST_RST_US);
         prep_us <= DIST_W'(`RNAC_PREP_RST_US);
         mask    <= `RNAC_MASK_RST;
      end else if (wr) begin
         case (addr)
            `RNAC_OFS_CTRL: ctrl    <= wdata[7:0];
            `RNAC_OFS_DIST: dist_us <= wdata[DIST_W-1:0];
            `RNAC_OFS_PREP: prep_us <= wdata[DIST_W-1:0];
            `RNAC_OFS_MASK: mask    <= wdata[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // status and interrupts
   // ----------------------------------------------------------------
   // sticky status, set wins over write-one-to-clear
   logic [2:0] sets;
   assign sets = {ev_prep, ev_post, ev_pre};
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         status <= 3'h0;
      end else if (wr && addr == `RNAC_OFS_STATUS) begin
         status <= (status & ~wdata[2:0]) | sets;
      end else begin
         status <= status | sets;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            `RNAC_OFS_CTRL:   rdata <= {24'h0, ctrl};
            `RNAC_OFS_DIST:   rdata <= 32'(dist_us);
            `RNAC_OFS_PREP:   rdata <= 32'(prep_us);
            `RNAC_OFS_STATUS: rdata <= {29'h0, status};
            `RNAC_OFS_MASK:   rdata <= {29'h0, mask};
            `RNAC_OFS_STATE:  rdata <= {27'h0, tx_amp_pin, rx_amp_pin,
                                        in_chain, state};
            default:          rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // lead timers
   // ----------------------------------------------------------------
   logic [DIST_W-1:0] next_pre_wait;
   logic [DIST_W-1:0] next_prep_wait;
   logic              pre_run;
   logic              pre_hit;
   logic              prep_run;
   logic              prep_hit;

   // wait so the notice lands the lead distance before first rx/tx
   always_comb begin
      next_pre_wait  = (evt_start_us > dist_us) ?
                       evt_start_us - dist_us : '0;
      next_prep_wait = (evt_start_us > prep_us) ?
                       evt_start_us - prep_us : '0;
   end

   rnac_us_timer #(.CLK_MHZ(`RNAC_CLK_MHZ), .W(DIST_W)) u_pre (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .load    (evt_sched && state == RNAC_IDLE),
      .load_us (next_pre_wait),
      .stop    (1'b0),
      .running (pre_run),
      .expired (pre_hit)
   );

   rnac_us_timer #(.CLK_MHZ(`RNAC_CLK_MHZ), .W(DIST_W)) u_prep (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .load    (evt_sched),
      .load_us (next_prep_wait),
      .stop    (1'b0),
      .running (prep_run),
      .expired (prep_hit)
   );

   // ----------------------------------------------------------------
   // notice sequencing
   // ----------------------------------------------------------------
   // per-event pairs follow the gap test
   // short gap keeps the chain open
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state    <= RNAC_IDLE;
         in_chain <= 1'b0;
         ev_pre   <= 1'b0;
         ev_post  <= 1'b0;
      end else begin
         ev_pre  <= 1'b0;
         ev_post <= 1'b0;
         case (state)
            RNAC_IDLE: begin
               if (evt_sched && !in_chain) begin
                  state <= RNAC_LEAD;
               end else if (evt_begin) begin
                  // an unannounced event outside a chain still opens with its pre
                  ev_pre <= pre_en && !in_chain;
                  state  <= RNAC_BUSY;
               end
            end
            RNAC_LEAD: begin
               if (evt_end) begin
                  // a cancelled event closes without notices
                  state <= RNAC_IDLE;
               end else if (pre_hit || evt_begin) begin
                  ev_pre <= pre_en;
                  state  <= RNAC_BUSY;
               end
            end
            RNAC_BUSY: begin
               if (evt_end) begin
                  state <= RNAC_IDLE;
                  if (more_pending && next_gap_us < dist_us) begin
                     in_chain <= 1'b1;
                  end else begin
                     in_chain <= 1'b0;
                     ev_post  <= post_en;
                  end
               end
            end
            default: state <= RNAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ev_prep <= 1'b0;
      end else begin
         ev_prep <= prep_hit;
      end
   end

   // ----------------------------------------------------------------
   // interrupt outputs
   // ----------------------------------------------------------------
   // shared line, masked sticky status
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         notice_irq        <= 1'b0;
         prep_irq          <= 1'b0;
         radio_done_notice <= 1'b0;
      end else begin
         notice_irq <= |(((status | sets) & mask) &
                         (3'h1 << `RNAC_ST_PRE | 3'h1 << `RNAC_ST_POST));
         prep_irq   <= |(((status | sets) & mask) &
                         (3'h1 << `RNAC_ST_PREP));
         radio_done_notice <= ev_post;
      end
   end

   // ----------------------------------------------------------------
   // amplifier requests
   // ----------------------------------------------------------------
   // ramp start is taken as ready minus the amp lead; the external
   // timer event link issues it RNAC_AMP_LEAD_CYC cycles before ready
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         amp_tx_on <= 1'b0;
      end else if (!amp_en) begin
         amp_tx_on <= 1'b0;
      end else if (radio_disabled) begin
         amp_tx_on <= 1'b0;
      end else if (radio_ramp_start) begin
         amp_tx_on <= evt_is_tx;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         amp_rx_on <= 1'b0;
      end else if (!amp_en) begin
         amp_rx_on <= 1'b0;
      end else if (radio_disabled) begin
         amp_rx_on <= 1'b0;
      end else if (radio_ramp_start) begin
         amp_rx_on <= !evt_is_tx;
      end
   end

   // ----------------------------------------------------------------
   // amplifier pin levels
   // ----------------------------------------------------------------
   // idle level is the inverse of the active polarity
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         // inactive level for the active-low reset polarity
         tx_amp_pin <= 1'b1;
      end else begin
         tx_amp_pin <= amp_tx_on ? tx_pol : !tx_pol;
      end
   end

   // rx pin follows its own polarity
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_amp_pin <= 1'b1;
      end else begin
         rx_amp_pin <= amp_rx_on ? rx_pol : !rx_pol;
      end
   end
endmodule

// file: tb/rnac_props.sv
// port checks for the radio notifier and amplifier pins
`timescale 1ns/1ps
module rnac_props (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [7:0]  addr,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        evt_end,
   input wire logic        radio_ramp_start,
   input wire logic        radio_disabled,
   input wire logic        notice_irq,
   input wire logic        prep_irq,
   input wire logic        radio_done_notice,
   input wire logic        tx_amp_pin,
   input wire logic        rx_amp_pin
);
   logic [1:0] up;
   logic [2:0] why;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // age since reset and recent causes of a pin change
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         up  <= 2'h0;
         why <= 3'h0;
      end else begin
         up  <= up[1] ? up : up + 2'h1;
         why <= {why[1:0], radio_ramp_start | radio_disabled | wr};
      end
   end

   AST_RDATA_IDLE:
      assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");
   AST_UNMAPPED:
      assert property ($past(rd) && $past(addr) > 8'h14 |-> rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_DONE_CAUSE:
      assert property ($rose(radio_done_notice) |->
                       $past(evt_end, 2) || $past(evt_end, 3))
      else $error("done notice without event end");
   AST_DONE_PULSE:
      assert property (radio_done_notice |=> !radio_done_notice)
      else $error("done notice longer than one cycle");
   AST_TX_CAUSE:
      assert property (up[1] && $changed(tx_amp_pin) |-> |why)
      else $error("tx pin moved without cause");
   AST_RX_CAUSE:
      assert property (up[1] && $changed(rx_amp_pin) |-> |why)
      else $error("rx pin moved without cause");
   AST_IRQ_FALL:
      assert property ($fell(notice_irq) |-> $past(wr) || $past(wr, 2))
      else $error("notice irq dropped without write");
   AST_PREP_FALL:
      assert property ($fell(prep_irq) |-> $past(wr) || $past(wr, 2))
      else $error("prep irq dropped without write");

   COV_DONE: cover property (radio_done_notice);
   COV_TX_ON: cover property ($rose(tx_amp_pin) ##0 up[1]);
   COV_PREP: cover property ($rose(prep_irq));
endmodule

bind rnac_top rnac_props u_rnac_props (.mclk(mclk), .rst_b(rst_b),
   .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .evt_end(evt_end),
   .radio_ramp_start(radio_ramp_start), .radio_disabled(radio_disabled),
   .notice_irq(notice_irq), .prep_irq(prep_irq),
   .radio_done_notice(radio_done_notice), .tx_amp_pin(tx_amp_pin),
   .rx_amp_pin(rx_amp_pin));

// file: tb/rnac_radio_model.sv
// radio side model: ramp, ready, event span and disable pulses
`timescale 1ns/1ps
module rnac_radio_model (
   input  wire logic mclk,
   input  wire logic go,
   output logic      radio_ramp_start = 1'b0,
   output logic      evt_begin = 1'b0,
   output logic      evt_end = 1'b0,
   output logic      radio_disabled = 1'b0
);
   int t = 300;

   // ready follows the ramp timer by 200 cycles
   always @(posedge mclk) begin
      radio_ramp_start <= go;
      evt_begin        <= (t == 199);
      evt_end          <= (t == 260);
      radio_disabled   <= (t == 262);
      if (go)
         t <= 0;
      else if (t < 300)
         t <= t + 1;
   end
endmodule

// file: tb/rnac_top_tb.sv
// self-checking bench for the radio notifier and amplifier pins
`timescale 1ns/1ps
module rnac_top_tb;
   logic        mclk, rst_b, wr, rd, go, evt_sched, evt_is_tx;
   logic        more_pending, evt_begin, evt_end, radio_ramp_start;
   logic        radio_disabled, notice_irq, prep_irq, radio_done_notice;
   logic        tx_amp_pin, rx_amp_pin;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [15:0] evt_start_us, next_gap_us;
   int          err_count = 0, check_count = 0, cyc = 0, dn = 0, s, d;

   rnac_top u_rnac_top (.mclk(mclk), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .evt_sched(evt_sched), .evt_start_us(evt_start_us),
      .evt_is_tx(evt_is_tx), .evt_begin(evt_begin), .evt_end(evt_end),
      .more_pending(more_pending), .next_gap_us(next_gap_us),
      .radio_ramp_start(radio_ramp_start), .radio_disabled(radio_disabled),
      .notice_irq(notice_irq), .prep_irq(prep_irq),
      .radio_done_notice(radio_done_notice), .tx_amp_pin(tx_amp_pin),
      .rx_amp_pin(rx_amp_pin));
   rnac_radio_model u_rnac_radio_model (.mclk(mclk), .go(go),
      .radio_ramp_start(radio_ramp_start), .evt_begin(evt_begin),
      .evt_end(evt_end), .radio_disabled(radio_disabled));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (radio_done_notice)
         dn <= dn + 1;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   // announce an event 12 us ahead and wait for the pre notice
   task automatic sched_pre();
      @(posedge mclk);
      evt_sched <= 1'b1;
      evt_start_us <= 16'h000c;
      s = cyc;
      @(posedge mclk);
      evt_sched <= 1'b0;
      while (notice_irq !== 1'b1 && cyc - s < 600)
         @(posedge mclk) #1;
   endtask

   task automatic run_evt(input logic tx, input logic [1:0] on,
                          input logic [1:0] off);
      d = dn;
      @(posedge mclk);
      evt_is_tx <= tx;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      // radio event, not notice, paces data
      wait (evt_begin);
      #1 chk(32'({tx_amp_pin, rx_amp_pin}), 32'(on));
      wait (radio_disabled);
      repeat (4) @(posedge mclk);
      #1 chk(32'({tx_amp_pin, rx_amp_pin}), 32'(off));
   endtask

   initial begin
      rst_b = 1'b0;
      {wr, rd, go, evt_sched, evt_is_tx, more_pending} = 6'h0;
      addr = 8'h00;
      wdata = 32'h0;
      evt_start_us = 16'h0;
      next_gap_us = 16'h0005;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      rreg(8'h00, 32'h0);
      rreg(8'h04, 32'h6cc);
      rreg(8'h08, 32'h64);
      rreg(8'h10, 32'h0);
      rreg(8'h18, 32'h0);
      run_evt(1'b1, 2'b11, 2'b11);
      $display("end reset and idle pins");
      wreg(8'h10, 32'h7);
      wreg(8'h04, 32'ha);
      wreg(8'h08, 32'h4);
      wreg(8'h00, 32'h0f);
      sched_pre();
      chk(32'(cyc - s inside {[78:128]}), 32'h1);
      rreg(8'h0c, 32'h1);
      while (prep_irq !== 1'b1 && cyc - s < 600)
         @(posedge mclk) #1;
      chk(32'(cyc - s inside {[318:368]}), 32'h1);
      wreg(8'h0c, 32'h7);
      repeat (2) @(posedge mclk);
      #1 chk(32'({notice_irq, prep_irq}), 32'h0);
      run_evt(1'b1, 2'b11, 2'b01);
      chk(dn - d, 1);
      rreg(8'h0c, 32'h2);
      wreg(8'h10, 32'h0);
      @(posedge mclk);
      #1 chk(32'(notice_irq), 32'h0);
      wreg(8'h10, 32'h7);
      wreg(8'h0c, 32'h7);
      $display("end notice pair and tx pin");
      sched_pre();
      wreg(8'h0c, 32'h7);
      more_pending <= 1'b1;
      run_evt(1'b0, 2'b00, 2'b01);
      chk(dn - d, 0);
      sched_pre();
      rreg(8'h0c, 32'h4);
      wreg(8'h0c, 32'h7);
      more_pending <= 1'b0;
      run_evt(1'b1, 2'b11, 2'b01);
      chk(dn - d, 1);
      rreg(8'h0c, 32'h2);
      $display("end short gap chain");
      wreg(8'h00, 32'h02);
      wreg(8'h0c, 32'h7);
      sched_pre();
      rreg(8'h0c, 32'h4);
      wreg(8'h0c, 32'h7);
      run_evt(1'b1, 2'b11, 2'b11);
      chk(dn - d, 1);
      rreg(8'h0c, 32'h2);
      $display("end single notice");
      wreg(8'h00, 32'h03);
      wreg(8'h0c, 32'h7);
      next_gap_us <= 16'h0014;
      more_pending <= 1'b1;
      sched_pre();
      rreg(8'h0c, 32'h1);
      run_evt(1'b0, 2'b11, 2'b11);
      chk(dn - d, 1);
      wreg(8'h0c, 32'h7);
      sched_pre();
      rreg(8'h0c, 32'h1);
      $display("end long gap pairs");
      complete_run();
   end
endmodule
